// ===== src/dac_aux_channel_controller.sv
// aux channel request/reply controller with payload words and status
`default_nettype none

module dac_aux_channel_controller #(
   parameter int TMO0_CYC = dac_pkg::DAC_TMO0_CYC,
   parameter int TMO1_CYC = dac_pkg::DAC_TMO1_CYC,
   parameter int TMO2_CYC = dac_pkg::DAC_TMO2_CYC,
   parameter int TMO3_CYC = dac_pkg::DAC_TMO3_CYC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // control
   input wire logic startWr,
   input wire logic [1:0] timeoutSel,
   input wire logic ioSelect,
   input wire logic [dac_pkg::DAC_LEN_W-1:0] reqLen,
   input wire logic doneClr,
   input wire logic rxErrClr,
   // payload words
   input wire logic payWr,
   input wire logic [dac_pkg::DAC_IDX_W-1:0] payIdx,
   input wire logic [31:0] payWrData,
   output logic [31:0] payRdData,
   // self-launching sources
   input wire logic selfRefreshEn,
   input wire logic timeCodeEn,
   input wire logic deepIdleEn,
   // status
   output logic busy,
   output logic done,
   output logic rxErr,
   output logic timeoutErr,
   output logic startRefused,
   output logic [dac_pkg::DAC_LEN_W-1:0] replyLen,
   // native aux link
   output dac_pkg::dac_byte_t natTx,
   output logic natTxValid,
   input wire logic natTxReady,
   input wire dac_pkg::dac_rx_t natRx,
   input wire logic natRxValid,
   // tunnelled aux link
   output dac_pkg::dac_byte_t tunTx,
   output logic tunTxValid,
   input wire logic tunTxReady,
   input wire dac_pkg::dac_rx_t tunRx,
   input wire logic tunRxValid
);

   // ==========================================
   // state
   dac_pkg::dac_state_t state_r, state_nxt;
   logic [31:0] payload [dac_pkg::DAC_WORDS];
   logic [dac_pkg::DAC_LEN_W-1:0] len_r;
   logic [dac_pkg::DAC_LEN_W-1:0] cnt_r;
   logic [dac_pkg::DAC_TMR_W-1:0] tmr_r;
   logic [1:0] tmoSel_r;
   logic ioSel_r;
   logic busy_r, done_r, rxErr_r, tmoErr_r, refused_r;
   logic [31:0] rdData_r;
   dac_pkg::dac_byte_t tx_r;
   logic natTxValid_r, tunTxValid_r;

   // ==========================================
   // decode
   wire autoSrcActive = selfRefreshEn | timeCodeEn | deepIdleEn;
   wire startOk = startWr & ~busy_r & ~autoSrcActive;
   wire startBad = startWr & ~busy_r & autoSrcActive;
   wire useTunnel = (ioSel_r == dac_pkg::DAC_IO_TUNNEL);
   wire txReady = useTunnel ? tunTxReady : natTxReady;
   wire txValid = natTxValid_r | tunTxValid_r;
   wire txTaken = txValid & txReady;
   wire dac_pkg::dac_rx_t rxIn = useTunnel ? tunRx : natRx;
   wire rxValid = useTunnel ? tunRxValid : natRxValid;
   wire rxTake = rxValid & ((state_r == dac_pkg::ST_WAIT) | (state_r == dac_pkg::ST_RECV));
   wire rxOverflow = rxTake & (cnt_r == dac_pkg::DAC_MAX_LEN);
   wire rxEnd = rxTake & rxIn.last;

   // byte index to word and lane, first byte in the top lane
   wire [dac_pkg::DAC_IDX_W-1:0] byteWord = cnt_r[dac_pkg::DAC_LEN_W-1:2];
   wire [1:0] byteLane = dac_pkg::DAC_TOP_LANE - cnt_r[1:0];
   wire [31:0] txWord = (byteWord < dac_pkg::DAC_IDX_W'(dac_pkg::DAC_WORDS)) ?
                        payload[byteWord] : 32'h0000_0000;
   wire [7:0] txByte = txWord[byteLane*8 +: 8];
   wire [dac_pkg::DAC_LEN_W-1:0] cntInc = cnt_r + dac_pkg::DAC_LEN_ONE;
   wire [dac_pkg::DAC_LEN_W-1:0] sendLen =
      (reqLen == 5'h00) ? dac_pkg::DAC_LEN_ONE :
      (reqLen > dac_pkg::DAC_MAX_LEN) ? dac_pkg::DAC_MAX_LEN : reqLen;

   // reply timeout chosen by the two-bit field
   wire [dac_pkg::DAC_TMR_W-1:0] tmoLimit =
      (tmoSel_r == dac_pkg::DAC_TMO_SEL0) ? dac_pkg::DAC_TMR_W'(TMO0_CYC) :
      (tmoSel_r == dac_pkg::DAC_TMO_SEL1) ? dac_pkg::DAC_TMR_W'(TMO1_CYC) :
      (tmoSel_r == dac_pkg::DAC_TMO_SEL2) ? dac_pkg::DAC_TMR_W'(TMO2_CYC) :
                                            dac_pkg::DAC_TMR_W'(TMO3_CYC);
   wire tmoHit = (state_r == dac_pkg::ST_WAIT) & ~rxValid & (tmr_r >= tmoLimit - 1'b1);

   wire lastTx = txTaken & (cntInc == len_r);
   wire finish = ((state_r == dac_pkg::ST_WAIT) | (state_r == dac_pkg::ST_RECV)) & (rxEnd | tmoHit);
   wire rxBad = rxTake & (rxIn.err | rxOverflow);
   wire hostWr = payWr & ~busy_r & (payIdx < dac_pkg::DAC_IDX_W'(dac_pkg::DAC_WORDS));

   // ==========================================
   // sequencer
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         dac_pkg::ST_IDLE: begin
            if (startOk) begin
               state_nxt = dac_pkg::ST_SEND;
            end
         end
         dac_pkg::ST_SEND: begin
            if (lastTx) begin
               state_nxt = dac_pkg::ST_WAIT;
            end
         end
         dac_pkg::ST_WAIT: begin
            if (finish) begin
               state_nxt = dac_pkg::ST_IDLE;
            end else if (rxTake) begin
               state_nxt = dac_pkg::ST_RECV;
            end
         end
         dac_pkg::ST_RECV: begin
            if (finish) begin
               state_nxt = dac_pkg::ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_r <= dac_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ==========================================
   // transaction bookkeeping
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         len_r <= '0;
         cnt_r <= '0;
         tmr_r <= '0;
         tmoSel_r <= dac_pkg::DAC_TMO_SEL0;
         ioSel_r <= dac_pkg::DAC_IO_NATIVE;
         replyLen <= '0;
      end else begin
         if (startOk) begin
            len_r <= sendLen;
            cnt_r <= '0;
            tmoSel_r <= timeoutSel;
            ioSel_r <= ioSelect;
         end else if (lastTx) begin
            cnt_r <= '0;
         end else if (txTaken | (rxTake & ~rxOverflow)) begin
            cnt_r <= cntInc;
         end
         if (state_r != dac_pkg::ST_WAIT) begin
            tmr_r <= '0;
         end else begin
            tmr_r <= tmr_r + 1'b1;
         end
         if (finish) begin
            replyLen <= (rxTake & ~rxOverflow) ? cntInc : cnt_r;
         end
      end
   end

   // ==========================================
   // transmit byte, held until the link takes it
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_r <= '0;
         natTxValid_r <= 1'b0;
         tunTxValid_r <= 1'b0;
      end else if ((state_r == dac_pkg::ST_SEND) & (~txValid | txTaken) & ~lastTx) begin
         tx_r.data <= txTaken ? 8'h00 : txByte;
         tx_r.last <= (cntInc == len_r);
         natTxValid_r <= ~txTaken & ~useTunnel;
         tunTxValid_r <= ~txTaken & useTunnel;
      end else if (txTaken) begin
         natTxValid_r <= 1'b0;
         tunTxValid_r <= 1'b0;
      end
   end

   // ==========================================
   // status flags, a set beats a clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
         rxErr_r <= 1'b0;
         tmoErr_r <= 1'b0;
         refused_r <= 1'b0;
      end else begin
         busy_r <= startOk | (busy_r & ~finish);
         done_r <= finish | (done_r & ~doneClr);
         rxErr_r <= rxBad | (rxErr_r & ~rxErrClr);
         tmoErr_r <= tmoHit | (tmoErr_r & ~(doneClr | startOk));
         refused_r <= startBad | (refused_r & ~startOk);
      end
   end

   // ==========================================
   // payload words: host writes when idle, reply bytes fill lanes
   genvar w;
   generate
      for (w = 0; w < dac_pkg::DAC_WORDS; w++) begin : g_word
         wire rxHere = rxTake & ~rxOverflow & (byteWord == dac_pkg::DAC_IDX_W'(w));
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               payload[w] <= 32'h0000_0000;
            end else if (hostWr & (payIdx == dac_pkg::DAC_IDX_W'(w))) begin
               payload[w] <= payWrData;
            end else if (rxHere) begin
               payload[w][byteLane*8 +: 8] <= rxIn.data;
            end
         end
      end
   endgenerate

   // reads show the word at payIdx one cycle later, also while busy
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdData_r <= 32'h0000_0000;
      end else if (payIdx < dac_pkg::DAC_IDX_W'(dac_pkg::DAC_WORDS)) begin
         rdData_r <= payload[payIdx];
      end else begin
         rdData_r <= 32'h0000_0000;
      end
   end

   // ==========================================
   // outputs
   assign payRdData = rdData_r;
   assign busy = busy_r;
   assign done = done_r;
   assign rxErr = rxErr_r;
   assign timeoutErr = tmoErr_r;
   assign startRefused = refused_r;
   assign natTx = tx_r;
   assign tunTx = tx_r;
   assign natTxValid = natTxValid_r;
   assign tunTxValid = tunTxValid_r;

endmodule : dac_aux_channel_controller

`default_nettype wire

// ===== src/dac_pkg.sv
// constants, carriers and states of the aux channel controller
// What this block does
// - self-refresh, time code, deep idle refuse starts
// - timeout select: 400, 600, 800, 4000 us
// - start write sets busy until transaction ends
// - completion: busy clear, done set, sticky
// - corrupt reply sets sticky error, write-one clears
// - five payload words: request in, reply out
// - io select routes to tunnel or native
`default_nettype none

package dac_pkg;
   // ==========================================
   // payload geometry
   localparam int DAC_WORDS = 5;
   localparam int DAC_BYTES = DAC_WORDS * 4;
   localparam int DAC_LEN_W = 5;
   localparam int DAC_IDX_W = 3;
   localparam logic [DAC_LEN_W-1:0] DAC_MAX_LEN = 5'h14;
   localparam logic [DAC_LEN_W-1:0] DAC_LEN_ONE = 5'h01;
   localparam logic [1:0] DAC_TOP_LANE = 2'h3;

   // ==========================================
   // reply timeout
   localparam int DAC_CLK_MHZ = 125;
   localparam int DAC_TMO0_US = 400;
   localparam int DAC_TMO1_US = 600;
   localparam int DAC_TMO2_US = 800;
   localparam int DAC_TMO3_US = 4000;
   localparam int DAC_TMO0_CYC = DAC_TMO0_US * DAC_CLK_MHZ;
   localparam int DAC_TMO1_CYC = DAC_TMO1_US * DAC_CLK_MHZ;
   localparam int DAC_TMO2_CYC = DAC_TMO2_US * DAC_CLK_MHZ;
   localparam int DAC_TMO3_CYC = DAC_TMO3_US * DAC_CLK_MHZ;
   localparam int DAC_TMR_W = 19;
   localparam logic [1:0] DAC_TMO_SEL0 = 2'h0;
   localparam logic [1:0] DAC_TMO_SEL1 = 2'h1;
   localparam logic [1:0] DAC_TMO_SEL2 = 2'h2;
   localparam logic [1:0] DAC_TMO_SEL3 = 2'h3;

   // ==========================================
   // io selection
   localparam logic DAC_IO_NATIVE = 1'b0;
   localparam logic DAC_IO_TUNNEL = 1'b1;

   // ==========================================
   // carriers and states
   typedef struct packed {
      logic [7:0] data;
      logic last;
   } dac_byte_t;

   typedef struct packed {
      logic [7:0] data;
      logic last;
      logic err;
   } dac_rx_t;

   typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT, ST_RECV} dac_state_t;
endpackage : dac_pkg

`default_nettype wire

// ===== dv/dac_aux_monitor.sv
// concurrent checks on the aux controller ports
`default_nettype none
module dac_aux_monitor (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // control
   input wire logic startWr,
   input wire logic doneClr,
   input wire logic rxErrClr,
   input wire logic selfRefreshEn,
   input wire logic timeCodeEn,
   input wire logic deepIdleEn,
   // status
   input wire logic busy,
   input wire logic done,
   input wire logic rxErr,
   input wire logic startRefused,
   // request link
   input wire logic natTxValid,
   input wire logic natTxReady,
   input wire logic tunTxValid,
   input wire dac_pkg::dac_byte_t natTx
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire logic autoSrc = selfRefreshEn | timeCodeEn | deepIdleEn;
   sequence s_go;
      startWr && !busy && !autoSrc;
   endsequence
   sequence s_launch;
      busy ##1 (natTxValid || tunTxValid);
   endsequence
   chk_start_launch: assert property (s_go |=> s_launch) else $error("start not launched");
   chk_refused_start: assert property (startWr && !busy && autoSrc |=> startRefused && !busy)
      else $error("start not refused");
   chk_idle_quiet: assert property (!busy |-> !natTxValid && !tunTxValid)
      else $error("link active while idle");
   chk_done_end: assert property ($fell(busy) |-> done) else $error("done missing at end");
   chk_done_hold: assert property (done && !doneClr && !startWr |=> done)
      else $error("done dropped");
   chk_err_hold: assert property (rxErr && !rxErrClr |=> rxErr) else $error("error dropped");
   chk_one_link: assert property (!(natTxValid && tunTxValid)) else $error("both links");
   chk_tx_hold: assert property (natTxValid && !natTxReady |=> natTxValid && $stable(natTx))
      else $error("request byte not held");
endmodule : dac_aux_monitor
bind dac_aux_channel_controller dac_aux_monitor u_mon (.clk_sys, .rst, .startWr, .doneClr,
   .rxErrClr, .selfRefreshEn, .timeCodeEn, .deepIdleEn, .busy, .done, .rxErr, .startRefused,
   .natTxValid, .natTxReady, .tunTxValid, .natTx);
`default_nettype wire

// ===== dv/dac_sink_model.sv
// sink model answering requests on one aux link
`default_nettype none
module dac_sink_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // request side
   input wire dac_pkg::dac_byte_t tx,
   input wire logic txValid,
   output logic txReady,
   // reply side
   output dac_pkg::dac_rx_t rx,
   output logic rxValid,
   // behaviour
   input wire logic slow,
   input wire logic [4:0] replyN,
   input wire logic [4:0] errAt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] k;
   logic [2:0] gap;
   logic run;
   always @(posedge clk_sys) begin
      rxValid <= 1'b0;
      rx <= {~rx.data, 2'b00};
      txReady <= slow ? ~txReady : 1'b1;
      if (rst) begin
         rx <= '0;
         txReady <= 1'b0;
         run <= 1'b0;
      end else if (txValid && txReady && tx.last) begin
         run <= replyN != 5'h00;
         gap <= 3'h5;
         k <= 5'h00;
      end else if (run && gap != 3'h0) begin
         gap <= gap - 3'h1;
      end else if (run) begin
         rxValid <= 1'b1;
         rx <= {8'ha0 + {3'h0, k}, k == replyN - 5'h01, k == errAt};
         k <= k + 5'h01;
         run <= k != replyN - 5'h01;
      end
   end
endmodule : dac_sink_model
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the aux channel controller
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, rst = 1, startWr = 0, ioSelect = 0, doneClr = 0, rxErrClr = 0;
   logic payWr = 0, selfRefreshEn = 0, timeCodeEn = 0, deepIdleEn = 0, slow = 0;
   logic [1:0] timeoutSel = 2'h3;
   logic [4:0] reqLen = 5'h01, replyN = 5'h00, errAt = 5'h1f, replyLen;
   logic [2:0] payIdx = 3'h0;
   logic [31:0] payWrData = 32'h0, payRdData;
   logic busy, done, rxErr, timeoutErr, startRefused, natTxValid, natTxReady, natRxValid;
   logic tunTxValid, tunTxReady, tunRxValid;
   dac_pkg::dac_byte_t natTx, tunTx;
   dac_pkg::dac_rx_t natRx, tunRx;
   int err_count = 0, tests_run = 0, cycles = 0, n;
   int lim[4] = '{40, 60, 80, 400};
   always #4 clk_sys = ~clk_sys;
   dac_aux_channel_controller #(.TMO0_CYC(40), .TMO1_CYC(60), .TMO2_CYC(80), .TMO3_CYC(400))
   DUT (.clk_sys, .rst, .startWr, .timeoutSel, .ioSelect, .reqLen, .doneClr, .rxErrClr, .payWr,
      .payIdx, .payWrData, .payRdData, .selfRefreshEn, .timeCodeEn, .deepIdleEn, .busy, .done,
      .rxErr, .timeoutErr, .startRefused, .replyLen, .natTx, .natTxValid, .natTxReady, .natRx,
      .natRxValid, .tunTx, .tunTxValid, .tunTxReady, .tunRx, .tunRxValid);
   dac_sink_model sinkNat (.clk_sys, .rst, .tx(natTx), .txValid(natTxValid), .txReady(natTxReady),
      .rx(natRx), .rxValid(natRxValid), .slow, .replyN, .errAt);
   dac_sink_model sinkTun (.clk_sys, .rst, .tx(tunTx), .txValid(tunTxValid), .txReady(tunTxReady),
      .rx(tunRx), .rxValid(tunRxValid), .slow, .replyN, .errAt);
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int c);
      repeat (c) @(posedge clk_sys);
      #1;
   endtask : cyc
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask : pulse
   task automatic go(input logic [1:0] sel, input logic io);
      timeoutSel = sel;
      ioSelect = io;
      pulse(startWr);
   endtask : go
   task automatic await;
      n = 0;
      while (busy === 1'b1 && n < 1000) begin
         cyc(1);
         n++;
      end
   endtask : await
   task automatic rd(input logic [2:0] i, input logic [31:0] exp);
      payIdx = i;
      cyc(1);
      chk(payRdData, exp);
   endtask : rd
   task automatic t_native;
      payIdx = 3'h0;
      payWrData = 32'h11223344;
      pulse(payWr);
      cyc(1);
      payIdx = 3'h1;
      payWrData = 32'h55667788;
      pulse(payWr);
      reqLen = 5'h06;
      replyN = 5'h03;
      slow = 1'b1;
      go(2'h3, 1'b0);
      chk(busy, 1);
      cyc(1);
      chk({natTxValid, natTx.data}, 9'h111);
      await();
      chk({busy, done, replyLen}, {2'b01, 5'h03});
      rd(3'h0, 32'ha0a1a244);
      rd(3'h1, 32'h55667788);
      rd(3'h5, 32'h0);
      pulse(doneClr);
      chk(done, 0);
      $display("native transfer test finished");
   endtask : t_native
   task automatic t_error;
      replyN = 5'h02;
      errAt = 5'h00;
      slow = 1'b0;
      go(2'h3, 1'b1);
      chk(tunTxValid | natTxValid, 0);
      cyc(1);
      chk({tunTxValid, natTxValid, tunTx.data}, {2'b10, 8'ha0});
      await();
      chk({done, rxErr}, 2'b11);
      pulse(rxErrClr);
      chk(rxErr, 0);
      pulse(doneClr);
      errAt = 5'h1f;
      $display("receive error test finished");
   endtask : t_error
   task automatic t_timeout;
      replyN = 5'h00;
      reqLen = 5'h01;
      chk({dac_pkg::DAC_TMO0_CYC, dac_pkg::DAC_TMO1_CYC}, {32'd50000, 32'd75000});
      chk({dac_pkg::DAC_TMO2_CYC, dac_pkg::DAC_TMO3_CYC}, {32'd100000, 32'd500000});
      for (int s = 0; s < 4; s++) begin
         go(s[1:0], 1'b0);
         await();
         chk(n >= lim[s] && n <= lim[s] + 8, 1);
         chk({done, timeoutErr}, 2'b11);
         pulse(doneClr);
      end
      $display("timeout test finished");
   endtask : t_timeout
   task automatic t_refuse;
      for (int k = 0; k < 3; k++) begin
         {deepIdleEn, timeCodeEn, selfRefreshEn} = 3'b001 << k;
         go(2'h3, 1'b0);
         chk({startRefused, busy}, 2'b10);
         {deepIdleEn, timeCodeEn, selfRefreshEn} = 3'b000;
         cyc(2);
      end
      go(2'h0, 1'b0);
      chk({startRefused, busy}, 2'b01);
      await();
      pulse(doneClr);
      $display("refused start test finished");
   endtask : t_refuse
   initial begin
      cyc(10);
      rst = 1'b0;
      cyc(1);
      chk({busy, done, rxErr, payRdData}, 35'h0);
      t_native();
      t_error();
      t_timeout();
      t_refuse();
      wrap_up();
   end
endmodule : tb
`default_nettype wire
